// [logic/monitor_regs_pkg.sv]
package monitor_regs_pkg;

  // Register pointer values seen on the two-wire bus.
  localparam logic [7:0] ADDR_OUTPUT_CODE_A    = 8'h01;
  localparam logic [7:0] ADDR_OUTPUT_CODE_B    = 8'h02;
  localparam logic [7:0] ADDR_OUTPUT_CODE_C    = 8'h03;
  localparam logic [7:0] ADDR_OUTPUT_CODE_D    = 8'h04;
  localparam logic [7:0] ADDR_REMOTE_TEMP_ONE  = 8'h02;
  localparam logic [7:0] ADDR_REMOTE_TEMP_TWO  = 8'h03;
  localparam logic [7:0] ADDR_INTERNAL_TEMP    = 8'h04;
  localparam logic [7:0] ADDR_VOLTAGE_ALARM    = 8'h05;
  localparam logic [7:0] ADDR_CURRENT_ALARM    = 8'h06;
  localparam logic [7:0] ADDR_TEMP_ALARM       = 8'h07;
  localparam logic [7:0] ADDR_AUTOCYCLE_SELECT = 8'h08;
  localparam logic [7:0] ADDR_OPERATING_CONFIG = 8'h09;

  // Result word, output code and config bit layout.
  localparam int ALARM_FLAG_BIT  = 15;
  localparam int TAG_MSB         = 14;
  localparam int TAG_LSB         = 12;
  localparam int OPEN_DIODE_BIT  = 11;
  localparam int READING_MSB     = 10;
  localparam int UNUSED_INT_MSB  = 14;
  localparam int UNUSED_INT_LSB  = 11;
  localparam int CODE_MSB        = 11;
  localparam int CFG_ALERT_BIT   = 2;
  localparam int CFG_CLEAR_BIT   = 1;

  // Channel identifiers carried in the result word.
  localparam logic [2:0] CH_TAG_REMOTE_ONE = 3'h6;
  localparam logic [2:0] CH_TAG_REMOTE_TWO = 3'h7;

  // Reset values and masks of reserved bits.
  localparam logic [15:0] CFG_RESET        = 16'h0000;
  localparam logic [7:0]  SEQ_USED_MASK    = 8'h3f;
  localparam logic [7:0]  CURRENT_USED_MASK = 8'h3f;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [7:0]  BYTE_ONES        = 8'hff;
  localparam logic [2:0]  BYTE_LAST_BIT    = 3'h7;
  localparam logic [3:0]  NIBBLE_ZERO      = 4'h0;

  // Result refresh interval.
  localparam int CLK_FREQ_MHZ           = 125;
  localparam int REFRESH_TIME_US        = 5000;
  localparam int REFRESH_CYCLES_DEFAULT = REFRESH_TIME_US * CLK_FREQ_MHZ;
  localparam int REFRESH_CNT_W          = 20;

  typedef enum logic [3:0] {
    S_IDLE      = 4'b0000,
    S_ADDR      = 4'b0001,
    S_ADDR_ACK  = 4'b0010,
    S_PTR       = 4'b0011,
    S_PTR_ACK   = 4'b0100,
    S_WDATA     = 4'b0101,
    S_WDATA_ACK = 4'b0110,
    S_RDATA     = 4'b0111,
    S_RDATA_ACK = 4'b1000
  } link_state_e;

endpackage

// [logic/monitor_result_alert_regs.sv]
// How it works
// [RQ1] Remote results: alarm flag, three-bit channel tag.
// [RQ2] Remote result bit 11 flags open diode.
// [RQ3] Readings are eleven-bit two's complement, bits 10-0.
// [RQ4] Results refresh by themselves about every 5 ms.
// [RQ5] Internal result: alarm flag, bits 14-11 zero.
// [RQ6] Bit 10 weighs -256, bit 0 weighs 0.25.
// [RQ7] Writes to 0x01-0x04 load output codes A-D.
// [RQ8] Output code keeps bits 11-0, drops 15-12.
// [RQ9] Master sends high byte first, then low.
// [RQ10] Three alert status bytes report limit events.
// [RQ11] Writing all ones clears whole alert byte.
// [RQ12] Writing a one clears only that alert bit.
// [RQ13] Config bits 1 and 2 set clear all alerts.
// [RQ14] Voltage alerts: low even bit, high odd bit.
// [RQ15] Current alerts, overrange bits 4-5, 7-6 reserved.
// [RQ16] Temperature alerts, overtemp bit 6, open bit 7.
// [RQ17] Autocycle select: bits 5-0 used, 7-6 reserved.
// [RQ18] Sixteen-bit config register resets to zero.
// [RQ19] Channel tags: remote one 6, remote two 7.
// [RQ20] Code writes never alter shared-address results.
`timescale 1ns/1ps
`default_nettype none

module monitor_result_alert_regs #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h22,  // Arbitrary bus address.
  parameter int         REFRESH_CYCLES = monitor_regs_pkg::REFRESH_CYCLES_DEFAULT
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic [10:0] REMOTE_TEMP_ONE_READING,
  input  wire logic        REMOTE_TEMP_ONE_OPEN,
  input  wire logic [10:0] REMOTE_TEMP_TWO_READING,
  input  wire logic        REMOTE_TEMP_TWO_OPEN,
  input  wire logic [10:0] INTERNAL_TEMP_READING,
  input  wire logic [7:0]  VOLTAGE_ALARM_EVENT,
  input  wire logic [7:0]  CURRENT_ALARM_EVENT,
  input  wire logic [7:0]  TEMP_ALARM_EVENT,
  output logic [11:0]      OUTPUT_CONVERTER_A_CODE,
  output logic [11:0]      OUTPUT_CONVERTER_B_CODE,
  output logic [11:0]      OUTPUT_CONVERTER_C_CODE,
  output logic [11:0]      OUTPUT_CONVERTER_D_CODE,
  output logic [7:0]       AUTOCYCLE_CHANNEL_SELECT,
  output logic [15:0]      OPERATING_CONFIGURATION,
  output logic             RESULT_REFRESH
);
  import monitor_regs_pkg::*;

  localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST = REFRESH_CNT_W'(REFRESH_CYCLES - 1);

  link_state_e               state;
  logic                      scl_q;
  logic                      sda_q;
  logic [2:0]                bit_cnt;
  logic [7:0]                shift_in;
  logic [7:0]                tx;
  logic [7:0]                ptr;
  logic                      byte_sel;
  logic                      is_read;
  logic                      ack_held;
  logic [7:0]                hi_byte;
  logic                      wr_pulse;
  logic [7:0]                wr_ptr;
  logic [15:0]               wr_word;
  logic [11:0]               out_code [4];
  logic [7:0]                voltage_status;
  logic [7:0]                current_status;
  logic [7:0]                temp_status;
  logic [10:0]               remote_one_reading;
  logic [10:0]               remote_two_reading;
  logic [10:0]               internal_reading;
  logic                      remote_one_open;
  logic                      remote_two_open;
  logic [REFRESH_CNT_W-1:0]  refresh_count;
  logic                      refresh_tick;
  logic [15:0]               rd_word;
  logic [15:0]               remote_one_word;
  logic [15:0]               remote_two_word;
  logic [15:0]               internal_word;
  logic [7:0]                rd_byte;
  logic [7:0]                byte_in;
  logic                      start_seen;
  logic                      stop_seen;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      last_bit;
  logic                      cfg_clear;
  logic [11:0]               wr_code;
  logic [7:0]                wr_low;

  // Registers holding a sixteen-bit word take two bytes on the bus.
  function automatic logic wide_reg(input logic [7:0] addr);
    return (addr >= ADDR_OUTPUT_CODE_A && addr <= ADDR_OUTPUT_CODE_D) ||
           addr == ADDR_OPERATING_CONFIG;
  endfunction

  // Bits that a bus write or a config clear removes from one alert byte.
  function automatic logic [7:0] clear_mask(input logic [7:0] addr);
    if (cfg_clear) begin
      return BYTE_ONES;  // see [RQ13]
    end
    if (wr_pulse && wr_ptr == addr) begin
      return wr_low;  // see [RQ11] see [RQ12]
    end
    return BYTE_ZERO;
  endfunction

  // Bus lines are taken as synchronous; the previous sample finds edges.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= SCL_IN;
      sda_q <= SDA_IN;
    end
  end

  assign start_seen = scl_q & SCL_IN & sda_q & ~SDA_IN;
  assign stop_seen  = scl_q & SCL_IN & ~sda_q & SDA_IN;
  assign scl_rise   = SCL_IN & ~scl_q;
  assign scl_fall   = ~SCL_IN & scl_q;
  assign byte_in    = {shift_in[6:0], SDA_IN};
  assign last_bit   = bit_cnt == BYTE_LAST_BIT;
  assign rd_byte    = (wide_reg(ptr) && !byte_sel) ? rd_word[15:8] : rd_word[7:0];
  assign wr_code    = wr_word[CODE_MSB:0];  // see [RQ8]
  assign wr_low     = wr_word[7:0];
  assign cfg_clear  = wr_pulse && wr_ptr == ADDR_OPERATING_CONFIG &&
                      wr_word[CFG_ALERT_BIT] && wr_word[CFG_CLEAR_BIT];

  // The pin is open drain, so the data output is a constant low.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end

  // Two-wire slave: a start restarts the frame from any state, and a
  // stop abandons it, so a master that loses sync can always recover.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state    <= S_IDLE;
      bit_cnt  <= 3'h0;
      shift_in <= BYTE_ZERO;
      tx       <= BYTE_ZERO;
      ptr      <= BYTE_ZERO;
      byte_sel <= 1'b0;
      is_read  <= 1'b0;
      ack_held <= 1'b0;
      hi_byte  <= BYTE_ZERO;
      wr_pulse <= 1'b0;
      wr_ptr   <= BYTE_ZERO;
      wr_word  <= 16'h0000;
      SDA_OE   <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (start_seen) begin
        state    <= S_ADDR;
        bit_cnt  <= 3'h0;
        ack_held <= 1'b0;
        SDA_OE   <= 1'b0;
      end else if (stop_seen) begin
        state  <= S_IDLE;
        SDA_OE <= 1'b0;
      end else if (scl_rise) begin
        shift_in <= byte_in;
        bit_cnt  <= bit_cnt + 3'h1;
        case (state)
          S_ADDR: begin
            if (last_bit) begin
              is_read <= SDA_IN;
              state   <= (byte_in[7:1] == DEVICE_ADDRESS) ? S_ADDR_ACK : S_IDLE;
            end
          end
          S_PTR: begin
            if (last_bit) begin
              ptr      <= byte_in;
              byte_sel <= 1'b0;
              state    <= S_PTR_ACK;
            end
          end
          S_WDATA: begin
            // High byte arrives first and is held until the low byte.
            if (last_bit) begin
              if (wide_reg(ptr) && !byte_sel) begin
                hi_byte <= byte_in;  // see [RQ9]
              end else begin
                wr_pulse <= 1'b1;
                wr_ptr   <= ptr;
                wr_word  <= {wide_reg(ptr) ? hi_byte : BYTE_ZERO, byte_in};
              end
              byte_sel <= wide_reg(ptr) & ~byte_sel;
              state    <= S_WDATA_ACK;
            end
          end
          S_RDATA: begin
            if (last_bit) begin
              byte_sel <= wide_reg(ptr) & ~byte_sel;
              state    <= S_RDATA_ACK;
            end
          end
          S_RDATA_ACK: begin
            // A low level is the master's acknowledge: send another byte.
            if (!SDA_IN) begin
              tx      <= rd_byte;
              bit_cnt <= 3'h0;
              state   <= S_RDATA;
            end else begin
              state <= S_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          S_ADDR_ACK, S_PTR_ACK, S_WDATA_ACK: begin
            if (!ack_held) begin
              SDA_OE   <= 1'b1;
              ack_held <= 1'b1;
            end else begin
              ack_held <= 1'b0;
              SDA_OE   <= 1'b0;
              bit_cnt  <= 3'h0;
              if (state == S_ADDR_ACK && is_read) begin
                SDA_OE <= ~rd_byte[7];
                tx     <= {rd_byte[6:0], 1'b0};
                state  <= S_RDATA;
              end else if (state == S_ADDR_ACK) begin
                state <= S_PTR;
              end else begin
                state <= S_WDATA;
              end
            end
          end
          S_RDATA: begin
            SDA_OE <= ~tx[7];
            tx     <= {tx[6:0], 1'b0};
          end
          S_RDATA_ACK: begin
            SDA_OE <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Result words; the channel tag and unused bits are fixed by wiring.
  assign remote_one_word = {temp_status[0] | temp_status[1], CH_TAG_REMOTE_ONE,  // see [RQ1] see [RQ19]
                            remote_one_open, remote_one_reading};  // see [RQ2] see [RQ3]
  assign remote_two_word = {temp_status[2] | temp_status[3], CH_TAG_REMOTE_TWO,  // see [RQ1] see [RQ19]
                            remote_two_open, remote_two_reading};  // see [RQ2] see [RQ3]
  assign internal_word   = {(|voltage_status) | (|current_status) | (|temp_status),
                            NIBBLE_ZERO, internal_reading};  // see [RQ5] see [RQ6]

  // Reads at the shared addresses return results, never the output codes.
  always_comb begin
    case (ptr)
      ADDR_REMOTE_TEMP_ONE:  rd_word = remote_one_word;  // see [RQ7]
      ADDR_REMOTE_TEMP_TWO:  rd_word = remote_two_word;
      ADDR_INTERNAL_TEMP:    rd_word = internal_word;
      ADDR_VOLTAGE_ALARM:    rd_word = {BYTE_ZERO, voltage_status};
      ADDR_CURRENT_ALARM:    rd_word = {BYTE_ZERO, current_status};
      ADDR_TEMP_ALARM:       rd_word = {BYTE_ZERO, temp_status};
      ADDR_AUTOCYCLE_SELECT: rd_word = {BYTE_ZERO, AUTOCYCLE_CHANNEL_SELECT};
      ADDR_OPERATING_CONFIG: rd_word = OPERATING_CONFIGURATION;
      default:               rd_word = 16'h0000;
    endcase
  end

  // One output code per converter, at consecutive addresses.
  for (genvar i = 0; i < 4; i++) begin : g_code
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        out_code[i] <= 12'h000;
      end else if (wr_pulse && wr_ptr == ADDR_OUTPUT_CODE_A + 8'(i)) begin
        out_code[i] <= wr_code;  // see [RQ7] see [RQ8]
      end
    end
  end

  assign OUTPUT_CONVERTER_A_CODE = out_code[0];
  assign OUTPUT_CONVERTER_B_CODE = out_code[1];
  assign OUTPUT_CONVERTER_C_CODE = out_code[2];
  assign OUTPUT_CONVERTER_D_CODE = out_code[3];

  // Autocycle select and configuration; reserved select bits stay zero.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AUTOCYCLE_CHANNEL_SELECT <= BYTE_ZERO;
      OPERATING_CONFIGURATION  <= CFG_RESET;  // see [RQ18]
    end else if (wr_pulse) begin
      if (wr_ptr == ADDR_AUTOCYCLE_SELECT) begin
        AUTOCYCLE_CHANNEL_SELECT <= wr_low & SEQ_USED_MASK;  // see [RQ17]
      end
      if (wr_ptr == ADDR_OPERATING_CONFIG) begin
        OPERATING_CONFIGURATION <= wr_word;  // see [RQ13] see [RQ18]
      end
    end
  end

  // Sticky alert bits: an event in the same cycle as its clear survives.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      voltage_status <= BYTE_ZERO;
      current_status <= BYTE_ZERO;
      temp_status    <= BYTE_ZERO;
    end else begin
      voltage_status <= VOLTAGE_ALARM_EVENT |
                        (voltage_status & ~clear_mask(ADDR_VOLTAGE_ALARM));  // see [RQ10] see [RQ14]
      current_status <= (CURRENT_ALARM_EVENT & CURRENT_USED_MASK) |
                        (current_status & ~clear_mask(ADDR_CURRENT_ALARM));  // see [RQ15]
      temp_status    <= TEMP_ALARM_EVENT |
                        (temp_status & ~clear_mask(ADDR_TEMP_ALARM));  // see [RQ16]
    end
  end

  // Free-running refresh timer; readings and open flags change only on its tick.
  assign refresh_tick = refresh_count == REFRESH_LAST;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      refresh_count  <= '0;
      RESULT_REFRESH <= 1'b0;
    end else begin
      refresh_count  <= refresh_tick ? '0 : refresh_count + 1'b1;  // see [RQ4]
      RESULT_REFRESH <= refresh_tick;
    end
  end

  // Bus writes never reach these, so shared addresses keep their results.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      remote_one_reading <= 11'h000;
      remote_two_reading <= 11'h000;
      internal_reading   <= 11'h000;
      remote_one_open    <= 1'b0;
      remote_two_open    <= 1'b0;
    end else if (refresh_tick) begin
      remote_one_reading <= REMOTE_TEMP_ONE_READING;  // see [RQ3] see [RQ4] see [RQ20]
      remote_two_reading <= REMOTE_TEMP_TWO_READING;
      internal_reading   <= INTERNAL_TEMP_READING;
      remote_one_open    <= REMOTE_TEMP_ONE_OPEN;  // see [RQ2]
      remote_two_open    <= REMOTE_TEMP_TWO_OPEN;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // Checked at the read mux, so a wrong routing of the shared addresses shows up.
  property p_tags;
    (ptr == ADDR_REMOTE_TEMP_ONE || ptr == ADDR_REMOTE_TEMP_TWO)
      |-> rd_word[TAG_MSB:TAG_LSB] ==
          ((ptr == ADDR_REMOTE_TEMP_ONE) ? CH_TAG_REMOTE_ONE : CH_TAG_REMOTE_TWO);
  endproperty
  a_tags: assert property (p_tags) else $error("Channel tag wrong.");  // see [RQ19]

  property p_int_zero;
    ptr == ADDR_INTERNAL_TEMP |-> rd_word[UNUSED_INT_MSB:UNUSED_INT_LSB] == NIBBLE_ZERO;
  endproperty
  a_int_zero: assert property (p_int_zero) else $error("Internal bits not zero.");  // see [RQ5]

  property p_open;
    refresh_tick |=> remote_one_word[OPEN_DIODE_BIT] == $past(REMOTE_TEMP_ONE_OPEN);
  endproperty
  a_open: assert property (p_open) else $error("Open flag not captured.");  // see [RQ2]

  property p_reading;
    refresh_tick |=> remote_two_word[READING_MSB:0] == $past(REMOTE_TEMP_TWO_READING);
  endproperty
  a_reading: assert property (p_reading) else $error("Reading not captured.");  // see [RQ3]

  property p_interval;
    refresh_tick |=> RESULT_REFRESH && !refresh_tick && refresh_count == '0;
  endproperty
  a_interval: assert property (p_interval) else $error("Refresh timer wrong.");  // see [RQ4]

  property p_code;
    wr_pulse && wr_ptr == ADDR_OUTPUT_CODE_B |=> OUTPUT_CONVERTER_B_CODE == $past(wr_code);
  endproperty
  a_code: assert property (p_code) else $error("Output code not loaded.");  // see [RQ8]

  property p_keep;
    wr_pulse && wr_ptr == ADDR_REMOTE_TEMP_ONE && !refresh_tick |=> $stable(remote_one_reading);
  endproperty
  a_keep: assert property (p_keep) else $error("Result altered by write.");  // see [RQ20]

  property p_w1c;
    wr_pulse && wr_ptr == ADDR_TEMP_ALARM && TEMP_ALARM_EVENT == BYTE_ZERO
      |=> (temp_status & $past(wr_low)) == BYTE_ZERO &&
          (temp_status & ~$past(wr_low)) == ($past(temp_status) & ~$past(wr_low));
  endproperty
  a_w1c: assert property (p_w1c) else $error("Alert clear wrong.");  // see [RQ12]

  property p_cfg_clear;
    cfg_clear |=> voltage_status == $past(VOLTAGE_ALARM_EVENT) &&
                  current_status == ($past(CURRENT_ALARM_EVENT) & CURRENT_USED_MASK) &&
                  temp_status == $past(TEMP_ALARM_EVENT);
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("Config clear failed.");  // see [RQ13]

  property p_set_wins;
    VOLTAGE_ALARM_EVENT != BYTE_ZERO
      |=> (voltage_status & $past(VOLTAGE_ALARM_EVENT)) == $past(VOLTAGE_ALARM_EVENT);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Alert event lost.");  // see [RQ10]

endmodule

`default_nettype wire

// [tb/monitor_result_alert_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module monitor_result_alert_regs_tb_top;
  import monitor_regs_pkg::*;

  localparam int          REFRESH = 50;
  localparam logic [6:0]  DEV     = 7'h22;  // Arbitrary bus address.
  localparam logic [10:0] TWELVE5 = 11'h032;  // 12.5 degrees is 8 + 4 + 0.5.

  logic        sys_clk = 1'b0;
  logic        reset_n;
  logic        scl;
  logic        sda_low;
  logic        sda_oe;
  logic        sda_out;
  logic        sda_wire;
  logic [10:0] r1;
  logic        r1_open;
  logic [10:0] r2;
  logic        r2_open;
  logic [10:0] ri;
  logic [7:0]  v_ev;
  logic [7:0]  c_ev;
  logic [7:0]  t_ev;
  logic [11:0] code_a;
  logic [11:0] code_b;
  logic [11:0] code_c;
  logic [11:0] code_d;
  logic [7:0]  sel;
  logic [15:0] cfg;
  logic        refresh;
  logic [15:0] code_in [4] = '{16'hf123, 16'h5abc, 16'ha800, 16'h0fff};
  logic        a;
  int          n;
  int          mismatches = 0;
  int          check_count = 0;

  // Clock and the pulled-up data wire, low when either side pulls it.
  always #4 sys_clk = ~sys_clk;
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

  two_wire_master m (.clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

  monitor_result_alert_regs #(.DEVICE_ADDRESS(DEV), .REFRESH_CYCLES(REFRESH)) dut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .REMOTE_TEMP_ONE_READING(r1), .REMOTE_TEMP_ONE_OPEN(r1_open),
    .REMOTE_TEMP_TWO_READING(r2), .REMOTE_TEMP_TWO_OPEN(r2_open),
    .INTERNAL_TEMP_READING(ri), .VOLTAGE_ALARM_EVENT(v_ev),
    .CURRENT_ALARM_EVENT(c_ev), .TEMP_ALARM_EVENT(t_ev),
    .OUTPUT_CONVERTER_A_CODE(code_a), .OUTPUT_CONVERTER_B_CODE(code_b),
    .OUTPUT_CONVERTER_C_CODE(code_c), .OUTPUT_CONVERTER_D_CODE(code_d),
    .AUTOCYCLE_CHANNEL_SELECT(sel), .OPERATING_CONFIGURATION(cfg),
    .RESULT_REFRESH(refresh));

  // Compares with case equality so an unknown never counts as a match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register write; 8-bit registers send only the low byte.
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d, input bit wide);
    m.start();
    m.put_byte({DEV, 1'b0}, a);
    check({15'h0000, a}, 16'h0001);
    m.put_byte(ptr, a);
    if (wide) m.put_byte(d[15:8], a);
    m.put_byte(d[7:0], a);
    m.stop();
  endtask

  // Register read through a repeated start, then compared.
  task automatic rchk(input logic [7:0] ptr, input bit wide, input logic [15:0] exp);
    logic [15:0] q;
    q = 16'h0000;
    m.start();
    m.put_byte({DEV, 1'b0}, a);
    m.put_byte(ptr, a);
    m.start();
    m.put_byte({DEV, 1'b1}, a);
    if (wide) m.get_byte(1'b1, q[15:8]);
    m.get_byte(1'b0, q[7:0]);
    m.stop();
    check(q, exp);
  endtask

  // One-cycle alarm events on all three status inputs together.
  task automatic pulse(input logic [7:0] v, input logic [7:0] c, input logic [7:0] t);
    @(posedge sys_clk);
    #1;
    v_ev = v;
    c_ev = c;
    t_ev = t;
    @(posedge sys_clk);
    #1;
    v_ev = 8'h00;
    c_ev = 8'h00;
    t_ev = 8'h00;
  endtask

  // Counts cycles between two refresh pulses, bounded so a dead refresh cannot hang.
  task automatic refresh_gap(output int gap);
    int k;
    k = 0;
    while (refresh !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    gap = 0;
    do begin
      @(posedge sys_clk);
      #1;
      gap++;
    end while (refresh !== 1'b1 && gap < 200);
  endtask

  // Cuts a hang short; the tests need about 14,000 cycles, this allows 50,000.
  initial begin
    #400_000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    r1 = 11'h400;
    r1_open = 1'b1;
    r2 = 11'h7ff;
    r2_open = 1'b0;
    ri = TWELVE5;
    v_ev = 8'h00;
    c_ev = 8'h00;
    t_ev = 8'h00;
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    check(cfg, 16'h0000);
    rchk(ADDR_OPERATING_CONFIG, 1'b1, 16'h0000);
    for (int i = 0; i < 4; i++) write_reg(8'(i + 1), code_in[i], 1'b1);
    check({4'h0, code_a}, {4'h0, code_in[0][11:0]});
    check({4'h0, code_b}, {4'h0, code_in[1][11:0]});
    check({4'h0, code_c}, {4'h0, code_in[2][11:0]});
    check({4'h0, code_d}, {4'h0, code_in[3][11:0]});
    rchk(ADDR_OUTPUT_CODE_A, 1'b1, 16'h0000);
    rchk(ADDR_REMOTE_TEMP_TWO, 1'b1, {1'b0, 3'h7, 1'b0, 11'h7ff});
    rchk(ADDR_INTERNAL_TEMP, 1'b1, {5'h00, TWELVE5});
    // A new reading must show once a refresh has latched it.
    r2 = 11'h5a5;
    refresh_gap(n);
    check(16'(n), 16'(REFRESH));
    rchk(ADDR_REMOTE_TEMP_TWO, 1'b1, {1'b0, 3'h7, 1'b0, 11'h5a5});
    pulse(8'ha5, 8'hff, 8'hc3);
    rchk(ADDR_VOLTAGE_ALARM, 1'b0, 16'h00a5);
    rchk(ADDR_CURRENT_ALARM, 1'b0, 16'h003f);
    rchk(ADDR_TEMP_ALARM, 1'b0, 16'h00c3);
    rchk(ADDR_REMOTE_TEMP_ONE, 1'b1, {1'b1, 3'h6, 1'b1, 11'h400});
    rchk(ADDR_INTERNAL_TEMP, 1'b1, {5'h10, TWELVE5});
    write_reg(ADDR_VOLTAGE_ALARM, 16'h0001, 1'b0);
    rchk(ADDR_VOLTAGE_ALARM, 1'b0, 16'h00a4);
    write_reg(ADDR_TEMP_ALARM, 16'h0002, 1'b0);
    rchk(ADDR_TEMP_ALARM, 1'b0, 16'h00c1);
    write_reg(ADDR_VOLTAGE_ALARM, 16'h00ff, 1'b0);
    rchk(ADDR_VOLTAGE_ALARM, 1'b0, 16'h0000);
    // Bit 2 alone must leave the status bytes standing.
    write_reg(ADDR_OPERATING_CONFIG, 16'h0004, 1'b1);
    rchk(ADDR_CURRENT_ALARM, 1'b0, 16'h003f);
    write_reg(ADDR_OPERATING_CONFIG, 16'h0006, 1'b1);
    check(cfg, 16'h0006);
    rchk(ADDR_CURRENT_ALARM, 1'b0, 16'h0000);
    rchk(ADDR_TEMP_ALARM, 1'b0, 16'h0000);
    write_reg(ADDR_AUTOCYCLE_SELECT, 16'h00ff, 1'b0);
    check({8'h00, sel}, 16'h003f);
    rchk(ADDR_AUTOCYCLE_SELECT, 1'b0, 16'h003f);
    rchk(8'h0a, 1'b0, 16'h0000);
    // A foreign address must not be acknowledged.
    m.start();
    m.put_byte({7'h23, 1'b0}, a);
    check({15'h0000, a}, 16'h0000);
    m.stop();
    report_and_stop();
  end
endmodule

`default_nettype wire

// [tb/two_wire_master.sv]
`timescale 1ns/1ps
`default_nettype none

// Bus master model; lines move 1 ns after a clock edge and each phase lasts 6 cycles.
module two_wire_master (
  input  wire logic clk,
  input  wire logic sda_wire,
  output var logic  scl,
  output var logic  sda_low
);
  // Both lines idle high, which the device needs when its reset is released.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Waits whole cycles, then steps off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Data moves only mid-low and is sampled mid-high, so a data change never looks like a stop.
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda_wire;
    tick(3);
    scl = 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    tick(3);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_low = 1'b1;
    tick(6);
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high and the bus is left idle.
  task automatic stop();
    tick(3);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_low = 1'b0;
    tick(6);
  endtask

  // Sends a byte, most significant bit first, and returns the acknowledge.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Receives a byte; more set to 1 acknowledges it and asks for another.
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~more, s);
  endtask
endmodule

`default_nettype wire
